/* File: logic/gpio_port_slice.sv */
// One byte-wide port: pad drive and the value a data read returns.
// Assumes pins are synchronous to the bus clock and alt_sel comes from a
// peripheral that has claimed the pin.
`timescale 1ns/100ps

module gpio_port_slice
    import gpio_ports_pkg::*;
#(
    parameter logic [7:0] PIN_MASK = 8'hFF
) (
    input  wire logic [7:0] latch,
    input  wire logic [7:0] dir,
    input  wire logic [7:0] alt_sel,
    input  wire logic [7:0] pin_in,
    output pad_drive_t      drive,
    output logic      [7:0] rd_val
);

    ////////////////////////////////////////////////////////////////////////
    // Each pin is handled the same way, so the logic is one generate loop.
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_pin
            if (PIN_MASK[i]) begin : g_used
                // A claimed pin keeps its buffer off whatever dir says.
                assign drive.oe[i]  = dir[i] & ~alt_sel[i];
                assign drive.out[i] = latch[i];
                // Claimed pins read latch or zero, free pins latch or pin.
                assign rd_val[i] = alt_sel[i] ? (dir[i] & latch[i]) :
                                   (dir[i] ? latch[i] : pin_in[i]);
            end else begin : g_absent
                // Missing pins read as zero and are never driven.
                assign drive.oe[i]  = 1'b0;
                assign drive.out[i] = 1'b0;
                assign rd_val[i]    = 1'b0;
            end
        end
    endgenerate

endmodule : gpio_port_slice

/* File: logic/gpio_ports_b_c_d.sv */
// Three parallel ports with data latches and direction registers on APB.
// Assumes pins, converter selects and timer selects are synchronous to mclk;
// the analog path itself lives outside this block.
//
// How it works
// - Analog port latch readable, writable, reset-immune.
// - Analog-selected bit reads zero if input.
// - Analog use ignores direction; direction picks read.
// - Direction one drives pin, zero floats it.
// - Reset clears analog port direction bits.
// - Analog port read: latch if output, else pin.
// - Data writes always hit the latch.
// - Six-pin port latches, reset leaves them alone.
// - Clock enable drives system clock on pin two.
// - Clock enable bit read/write, cleared by reset.
// - Reset clears six-pin directions and clock enable.
// - Six-pin read: latch if output, else pin.
// - Timer port has latch and direction per pin.
// - Seven timer-port pins become converter channels.
// - Timer use ignores direction; direction picks read.
// - Pins six and four feed timer clocks.
// - Timer port read: latch if output, else pin.
// - Reset clears timer port direction bits.
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`include "gpio_ports_defines.svh"

module gpio_ports_b_c_d
    import gpio_ports_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  analog_pin_in,
    output logic      [7:0]  analog_pin_out,
    output logic      [7:0]  analog_pin_oe,
    input  wire logic [5:0]  six_pin_in,
    output logic      [5:0]  six_pin_out,
    output logic      [5:0]  six_pin_oe,
    input  wire logic [7:0]  timer_pin_in,
    output logic      [7:0]  timer_pin_out,
    output logic      [7:0]  timer_pin_oe,
    input  wire logic [7:0]  analog_sel_b,
    input  wire logic [6:0]  analog_sel_d,
    input  wire logic        first_tmr_clk_sel,
    input  wire logic        second_tmr_clk_sel,
    output logic             first_timer_ext_clock,
    output logic             second_timer_ext_clock
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops; the direction and bus registers also use the copy.
    logic rst_n_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_n_meta_ff <= 1'b0;
            rst_n_ff      <= 1'b0;
        end else begin
            rst_n_meta_ff <= 1'b1;
            rst_n_ff      <= rst_n_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode, shared by the read and the write path.
    function automatic reg_sel_t decode_sel(input logic [11:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        if (addr[1:0] == 2'h0 && addr[11:5] == 7'h00) begin
            unique case (addr[4:2])
                `IDX_ANALOG_DATA: sel = SEL_ANALOG_DATA;
                `IDX_SIX_DATA:    sel = SEL_SIX_DATA;
                `IDX_TIMER_DATA:  sel = SEL_TIMER_DATA;
                `IDX_ANALOG_DIR:  sel = SEL_ANALOG_DIR;
                `IDX_SIX_DIR:     sel = SEL_SIX_DIR;
                `IDX_TIMER_DIR:   sel = SEL_TIMER_DIR;
                default:          sel = SEL_NONE;
            endcase
        end
        return sel;
    endfunction : decode_sel

    reg_sel_t bus_sel;
    logic     acc_start;
    logic     acc_done;
    logic     wr_done;
    logic     pready_ff;

    assign bus_sel = decode_sel(paddr);
    // The first access cycle prepares the answer; the second completes it.
    assign acc_start = psel & penable & ~pready_ff & ce;
    assign acc_done  = psel & penable & pready_ff & ce;
    assign wr_done   = acc_done & pwrite;
    // Gating with ce keeps a frozen block from completing a transfer.
    assign pready    = pready_ff & ce;

    ////////////////////////////////////////////////////////////////////////
    // Port registers.  Data latches have no reset, as the ports require.
    logic [7:0] analog_latch_ff;
    logic [5:0] six_latch_ff;
    logic [7:0] timer_latch_ff;
    logic [7:0] analog_dir_ff;
    logic [5:0] six_dir_ff;
    logic       clk_out_en_ff;
    logic [7:0] timer_dir_ff;

    // Latches take every write, whatever the direction bits say.
    always_ff @(posedge mclk) begin
        if (wr_done) begin
            if (bus_sel == SEL_ANALOG_DATA) begin
                analog_latch_ff <= pwdata[7:0];
            end
            if (bus_sel == SEL_SIX_DATA) begin
                six_latch_ff <= pwdata[5:0];
            end
            if (bus_sel == SEL_TIMER_DATA) begin
                timer_latch_ff <= pwdata[7:0];
            end
        end
    end

    // Direction bits and the clock-output enable start cleared.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            analog_dir_ff <= `DIR_RESET;
            six_dir_ff    <= 6'h00;
            clk_out_en_ff <= 1'b0;
            timer_dir_ff  <= `DIR_RESET;
        end else if (!rst_n_ff) begin
            analog_dir_ff <= `DIR_RESET;
            six_dir_ff    <= 6'h00;
            clk_out_en_ff <= 1'b0;
            timer_dir_ff  <= `DIR_RESET;
        end else if (wr_done) begin
            if (bus_sel == SEL_ANALOG_DIR) begin
                analog_dir_ff <= pwdata[7:0];
            end
            if (bus_sel == SEL_SIX_DIR) begin
                six_dir_ff    <= pwdata[5:0];
                clk_out_en_ff <= pwdata[`CLK_OUT_EN_BIT];
            end
            if (bus_sel == SEL_TIMER_DIR) begin
                timer_dir_ff <= pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alternate-function claims from the converter, the timers and the clock-output enable.
    logic [7:0] timer_alt;
    logic [7:0] six_alt;

    always_comb begin
        timer_alt = {1'b0, analog_sel_d};
        timer_alt[`FIRST_TMR_PIN]  = timer_alt[`FIRST_TMR_PIN] | first_tmr_clk_sel;
        timer_alt[`SECOND_TMR_PIN] = timer_alt[`SECOND_TMR_PIN] | second_tmr_clk_sel;
        six_alt = 8'h00;
        six_alt[`CLK_OUT_PIN] = clk_out_en_ff;
    end

    ////////////////////////////////////////////////////////////////////////
    // The three ports share one slice design.
    pad_drive_t analog_drive;
    pad_drive_t six_drive;
    pad_drive_t timer_drive;
    logic [7:0] analog_rd;
    logic [7:0] six_rd;
    logic [7:0] timer_rd;

    gpio_port_slice #(
        .PIN_MASK (`ANALOG_PIN_MASK)
    ) u_analog_port (
        .latch   (analog_latch_ff),
        .dir     (analog_dir_ff),
        .alt_sel (analog_sel_b),
        .pin_in  (analog_pin_in),
        .drive   (analog_drive),
        .rd_val  (analog_rd)
    );

    gpio_port_slice #(
        .PIN_MASK (`SIX_PIN_MASK)
    ) u_six_port (
        .latch   ({2'b00, six_latch_ff}),
        .dir     ({2'b00, six_dir_ff}),
        .alt_sel (six_alt),
        .pin_in  ({2'b00, six_pin_in}),
        .drive   (six_drive),
        .rd_val  (six_rd)
    );

    gpio_port_slice #(
        .PIN_MASK (`TIMER_PIN_MASK)
    ) u_timer_port (
        .latch   (timer_latch_ff),
        .dir     (timer_dir_ff),
        .alt_sel (timer_alt),
        .pin_in  (timer_pin_in),
        .drive   (timer_drive),
        .rd_val  (timer_rd)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pad outputs.  The clock pin carries mclk itself; a gated clock on a
    // pad is acceptable here because nothing inside the block uses it.
    always_comb begin
        analog_pin_out = analog_drive.out;
        analog_pin_oe  = analog_drive.oe;
        six_pin_out    = six_drive.out[5:0];
        six_pin_oe     = six_drive.oe[5:0];
        if (clk_out_en_ff) begin
            six_pin_out[`CLK_OUT_PIN] = mclk;
            six_pin_oe[`CLK_OUT_PIN]  = 1'b1;
        end
        timer_pin_out = timer_drive.out;
        timer_pin_oe  = timer_drive.oe;
    end

    // Timer clock inputs are sampled, so the timers see clean levels.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            first_timer_ext_clock  <= 1'b0;
            second_timer_ext_clock <= 1'b0;
        end else if (ce) begin
            first_timer_ext_clock  <= first_tmr_clk_sel & timer_pin_in[`FIRST_TMR_PIN];
            second_timer_ext_clock <= second_tmr_clk_sel & timer_pin_in[`SECOND_TMR_PIN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and the answer are captured in the first access cycle.
    logic [7:0] nxt_rdata;
    logic       nxt_err;

    always_comb begin
        nxt_rdata = 8'h00;
        nxt_err   = 1'b0;
        unique case (bus_sel)
            SEL_ANALOG_DATA: nxt_rdata = analog_rd;
            SEL_SIX_DATA:    nxt_rdata = six_rd;
            SEL_TIMER_DATA:  nxt_rdata = timer_rd;
            SEL_ANALOG_DIR:  nxt_rdata = analog_dir_ff;
            SEL_SIX_DIR:     nxt_rdata = {clk_out_en_ff, 1'b0, six_dir_ff};
            SEL_TIMER_DIR:   nxt_rdata = timer_dir_ff;
            SEL_NONE:        nxt_err   = 1'b1;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pready_ff <= 1'b0;
            prdata    <= 32'h0000_0000;
            pslverr   <= 1'b0;
        end else if (!rst_n_ff) begin
            pready_ff <= 1'b0;
            prdata    <= 32'h0000_0000;
            pslverr   <= 1'b0;
        end else if (acc_start) begin
            pready_ff <= 1'b1;
            prdata    <= pwrite ? 32'h0000_0000 : {24'h00_0000, nxt_rdata};
            pslverr   <= nxt_err;
        end else if (acc_done) begin
            pready_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks kept beside the logic they guard.

    chk_analog_dir_reset: assert property (
        @(posedge mclk) $rose(rst_n_ff) |-> (analog_dir_ff == 8'h00 && analog_pin_oe == 8'h00))
        else $error("analog port not all inputs after reset");

    chk_six_dir_reset: assert property (
        @(posedge mclk) $rose(rst_n_ff) |-> (six_pin_oe == 6'h00 && !clk_out_en_ff))
        else $error("six-pin port not all inputs after reset");

    chk_timer_dir_reset: assert property (
        @(posedge mclk) $rose(rst_n_ff) |-> timer_pin_oe == 8'h00)
        else $error("timer port not all inputs after reset");

    chk_analog_latch_write: assert property (
        @(posedge mclk) disable iff (!rst_n_ff)
        (wr_done && bus_sel == SEL_ANALOG_DATA) |=> analog_latch_ff == $past(pwdata[7:0]))
        else $error("analog latch missed a write");

    chk_analog_drive_dir: assert property (
        @(posedge mclk) disable iff (!rst_n_ff)
        analog_pin_oe == (analog_dir_ff & ~analog_sel_b))
        else $error("analog pad enable does not follow direction");

    chk_analog_read_zero: assert property (
        @(posedge mclk) disable iff (!rst_n_ff)
        (acc_start && !pwrite && bus_sel == SEL_ANALOG_DATA && analog_sel_b == 8'hFF
         && analog_dir_ff == 8'h00) |=> (pready_ff && prdata[7:0] == 8'h00))
        else $error("analog channel input bit did not read zero");

    chk_analog_read_pin: assert property (
        @(posedge mclk) disable iff (!rst_n_ff)
        (acc_start && !pwrite && bus_sel == SEL_ANALOG_DATA && analog_sel_b == 8'h00)
        |=> prdata[7:0] == (($past(analog_dir_ff) & $past(analog_latch_ff))
                           | (~$past(analog_dir_ff) & $past(analog_pin_in))))
        else $error("analog port read mixes latch and pin wrongly");

    chk_six_read_mix: assert property (
        @(posedge mclk) disable iff (!rst_n_ff)
        (acc_start && !pwrite && bus_sel == SEL_SIX_DATA && !clk_out_en_ff)
        |=> prdata[7:0] == {2'b00, ($past(six_dir_ff) & $past(six_latch_ff))
                                   | (~$past(six_dir_ff) & $past(six_pin_in))})
        else $error("six-pin port read mixes latch and pin wrongly");

    chk_clk_out_pin: assert property (
        @(posedge mclk) disable iff (!rst_n_ff)
        clk_out_en_ff |-> six_pin_oe[`CLK_OUT_PIN])
        else $error("clock pin not driven while enabled");

    chk_clk_en_write: assert property (
        @(posedge mclk) disable iff (!rst_n_ff)
        (wr_done && bus_sel == SEL_SIX_DIR) |=> clk_out_en_ff == $past(pwdata[7]))
        else $error("clock enable did not take the write");

    chk_timer_claim: assert property (
        @(posedge mclk) disable iff (!rst_n_ff)
        (first_tmr_clk_sel || analog_sel_d[6]) |-> !timer_pin_oe[`FIRST_TMR_PIN])
        else $error("claimed timer-port pin is driven");

    chk_timer_clock: assert property (
        @(posedge mclk) disable iff (!rst_n_ff)
        (ce && second_tmr_clk_sel) |=> second_timer_ext_clock == $past(timer_pin_in[4]))
        else $error("second timer clock does not follow its pin");

    chk_timer_read_zero: assert property (
        @(posedge mclk) disable iff (!rst_n_ff)
        (acc_start && !pwrite && bus_sel == SEL_TIMER_DATA && analog_sel_d == 7'h7F
         && timer_dir_ff == 8'h00) |=> prdata[6:0] == 7'h00)
        else $error("timer-port channel input bit did not read zero");

    chk_bus_answer: assert property (
        @(posedge mclk) disable iff (!rst_n_ff)
        acc_start |=> pready_ff ##1 !pready_ff || !ce)
        else $error("bus answer not given one cycle after access");

endmodule : gpio_ports_b_c_d

/* File: logic/gpio_ports_defines.svh */
// Register indices, field positions and reset values for the port block.
// Assumes the includer maps byte address = index * 4 on a 32-bit bus.
`ifndef GPIO_PORTS_DEFINES_SVH
`define GPIO_PORTS_DEFINES_SVH

// Register indices; the byte address is four times the index.
`define IDX_ANALOG_DATA   3'h1
`define IDX_SIX_DATA      3'h2
`define IDX_TIMER_DATA    3'h3
`define IDX_ANALOG_DIR    3'h5
`define IDX_SIX_DIR       3'h6
`define IDX_TIMER_DIR     3'h7

// Field positions.
`define CLK_OUT_EN_BIT    7
`define CLK_OUT_PIN       2
`define FIRST_TMR_PIN     6
`define SECOND_TMR_PIN    4

// Implemented pins per port and reset value of every direction bit.
`define ANALOG_PIN_MASK   8'hFF
`define SIX_PIN_MASK      8'h3F
`define TIMER_PIN_MASK    8'hFF
`define DIR_RESET         8'h00

`endif

/* File: logic/gpio_ports_pkg.sv */
// Types shared by the port block and its per-port slice.
// Assumes the defines header supplies all numeric constants.
package gpio_ports_pkg;

    // Pad drive of one port: output level and output enable per pin.
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pad_drive_t;

    // Register selected by a bus address.
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_ANALOG_DATA,
        SEL_SIX_DATA,
        SEL_TIMER_DATA,
        SEL_ANALOG_DIR,
        SEL_SIX_DIR,
        SEL_TIMER_DIR
    } reg_sel_t;

endpackage : gpio_ports_pkg

/* File: verification/gpio_pad_model.sv */
// Pad model for one port: what the board and the pin itself show to the block.
// Assumes the bench gives the external level that stands on each undriven pin.
`timescale 1ns/100ps

module gpio_pad_model #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] pad_out,
    input  wire logic [W-1:0] pad_oe,
    input  wire logic [W-1:0] ext_level,
    output logic      [W-1:0] pad_in
);
    // A driven pin reads back its own level; a floating one shows the board.
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule : gpio_pad_model

/* File: verification/gpio_ports_b_c_d_bench.sv */
// Self-checking bench for the three-port block, driven over APB.
// Assumes exactly one wait state per transfer and pads modelled by loopback.
`timescale 1ns/100ps
`include "gpio_ports_defines.svh"

module gpio_ports_b_c_d_bench;
    import gpio_ports_pkg::*;

    localparam logic [11:0] A_AD = {7'h00, `IDX_ANALOG_DATA, 2'b00};
    localparam logic [11:0] A_SD = {7'h00, `IDX_SIX_DATA, 2'b00};
    localparam logic [11:0] A_TD = {7'h00, `IDX_TIMER_DATA, 2'b00};
    localparam logic [11:0] A_AR = {7'h00, `IDX_ANALOG_DIR, 2'b00};
    localparam logic [11:0] A_SR = {7'h00, `IDX_SIX_DIR, 2'b00};
    localparam logic [11:0] A_TR = {7'h00, `IDX_TIMER_DIR, 2'b00};

    logic        mclk, nrst, ce, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic [7:0]  ext_b, ext_d, b_in, b_out, b_oe, d_in, d_out, d_oe, sel_b;
    logic [5:0]  ext_c, c_in, c_out, c_oe;
    logic [6:0]  sel_d;
    logic        sel_t1, sel_t2, t1_clk, t2_clk, rd_err;
    int          n_errors, samples_checked;

    gpio_ports_b_c_d i_gpio_ports_b_c_d (.mclk(mclk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .analog_pin_in(b_in), .analog_pin_out(b_out), .analog_pin_oe(b_oe), .six_pin_in(c_in),
        .six_pin_out(c_out), .six_pin_oe(c_oe), .timer_pin_in(d_in), .timer_pin_out(d_out),
        .timer_pin_oe(d_oe), .analog_sel_b(sel_b), .analog_sel_d(sel_d), .first_tmr_clk_sel(sel_t1),
        .second_tmr_clk_sel(sel_t2), .first_timer_ext_clock(t1_clk), .second_timer_ext_clock(t2_clk));
    gpio_pad_model #(.W(8)) i_gpio_pad_model_b (.pad_out(b_out), .pad_oe(b_oe), .ext_level(ext_b), .pad_in(b_in));
    gpio_pad_model #(.W(6)) i_gpio_pad_model_c (.pad_out(c_out), .pad_oe(c_oe), .ext_level(ext_c), .pad_in(c_in));
    gpio_pad_model #(.W(8)) i_gpio_pad_model_d (.pad_out(d_out), .pad_oe(d_oe), .ext_level(ext_d), .pad_in(d_in));

    ////////////////////////////////////////////////////////////////////////////
    // Clock, and a watchdog sized well above the few hundred cycles needed.
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        print_verdict();
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    ////////////////////////////////////////////////////////////////////////////
    // One APB transfer; the request holds until pready is seen at an edge.
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= {24'h000000, wd};
        penable <= 1'b0;
        @(posedge mclk);
        penable <= 1'b1;
        // Only pready or the watchdog ends this wait; the count is then held to one wait state.
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1);
        check("wait cycles", n, 2);
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input string name, input logic [11:0] addr, input logic [7:0] exp);
        apb(1'b0, addr, 8'h00);
        check(name, rd_data, {24'h000000, exp});
    endtask : rd_chk

    // Read value worked out per bit: latch for outputs, zero for claimed inputs, pad otherwise.
    function automatic logic [7:0] exp_rd(input logic [7:0] l, d, s, p);
        return (d & l) | (~d & ~s & p);
    endfunction : exp_rd

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_reset_state();
        rd_chk("analog dir", A_AR, `DIR_RESET);
        rd_chk("six dir", A_SR, `DIR_RESET);
        rd_chk("timer dir", A_TR, `DIR_RESET);
        check("oe all", {b_oe, c_oe, d_oe}, 22'h0);
        check("tmr clk", {t1_clk, t2_clk}, 2'b00);
        $display("test reset_state done");
    endtask : t_reset_state

    task automatic t_analog();
        apb(1'b1, A_AR, 8'h00);
        apb(1'b1, A_AD, 8'hA5);
        rd_chk("analog pin read", A_AD, 8'h3C);
        apb(1'b1, A_AR, 8'hFF);
        @(negedge mclk);
        check("analog drive", {b_oe, b_out}, 16'hFFA5);
        rd_chk("analog latch read", A_AD, 8'hA5);
        sel_b <= 8'hF0;
        apb(1'b1, A_AR, 8'h3C);
        @(negedge mclk);
        check("analog claimed oe", b_oe, 8'h3C & ~8'hF0);
        rd_chk("analog claimed read", A_AD, exp_rd(8'hA5, 8'h3C, 8'hF0, 8'h3C));
        sel_b <= 8'hFF;
        apb(1'b1, A_AR, 8'h00);
        rd_chk("analog channel input", A_AD, 8'h00);
        sel_b <= 8'h00;
        $display("test analog done");
    endtask : t_analog

    task automatic t_six();
        apb(1'b1, A_SR, 8'hC0);
        rd_chk("six dir clk en", A_SR, 8'h80);
        @(negedge mclk);
        // The clock pin follows mclk combinationally, so let it settle first.
        #10;
        check("clk pin oe", c_oe, 6'h04);
        check("clk pin low", c_out[`CLK_OUT_PIN], 1'b0);
        @(posedge mclk);
        #10;
        check("clk pin high", c_out[`CLK_OUT_PIN], 1'b1);
        apb(1'b1, A_SD, 8'hFF);
        rd_chk("six pin read", A_SD, 8'h15 & ~8'h04);
        apb(1'b1, A_SR, 8'h3F);
        @(negedge mclk);
        check("six drive", {c_oe, c_out}, 12'hFFF);
        rd_chk("six latch read", A_SD, 8'h3F);
        $display("test six done");
    endtask : t_six

    task automatic t_timer();
        logic [7:0] s, oe, pin;
        s   = 8'h4F;
        oe  = 8'hF0 & ~s;
        pin = (oe & 8'hC3) | (~oe & 8'h5A);
        sel_d  <= 7'h0F;
        sel_t1 <= 1'b1;
        apb(1'b1, A_TD, 8'hC3);
        apb(1'b1, A_TR, 8'hF0);
        @(negedge mclk);
        check("timer oe", d_oe, oe);
        rd_chk("timer read", A_TD, exp_rd(8'hC3, 8'hF0, s, pin));
        repeat (2) @(posedge mclk);
        check("first clk high", t1_clk, 1'b1);
        ext_d <= 8'h1A;
        repeat (2) @(posedge mclk);
        check("first clk low", t1_clk, 1'b0);
        sel_t1 <= 1'b0;
        sel_t2 <= 1'b1;
        ext_d  <= 8'h5A;
        repeat (2) @(posedge mclk);
        check("second clk high", t2_clk, 1'b1);
        // A low clock enable must hold the sampled timer clock still.
        ce    <= 1'b0;
        ext_d <= 8'h4A;
        repeat (3) @(posedge mclk);
        check("frozen clk", t2_clk, 1'b1);
        ce    <= 1'b1;
        repeat (2) @(posedge mclk);
        check("thawed clk", t2_clk, 1'b0);
        sel_t2 <= 1'b0;
        ext_d  <= 8'h5A;
        sel_d  <= 7'h7F;
        apb(1'b1, A_TR, 8'h00);
        rd_chk("timer channel input", A_TD, 8'h00);
        sel_d  <= 7'h00;
        apb(1'b1, A_TR, 8'h0F);
        rd_chk("timer pin read", A_TD, 8'h53);
        $display("test timer done");
    endtask : t_timer

    task automatic t_unmapped();
        logic [11:0] bad [4];
        bad = '{12'h000, 12'h005, 12'h010, 12'h020};
        foreach (bad[i]) begin
            apb(i[0], bad[i], 8'hFF);
            check("unmapped err", rd_err, 1'b1);
            if (i[0] == 1'b0) check("unmapped data", rd_data, 32'h0);
        end
        rd_chk("timer after bad writes", A_TR, 8'h0F);
        check("mapped err", rd_err, 1'b0);
        $display("test unmapped done");
    endtask : t_unmapped

    task automatic t_rerun_reset();
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
        t_reset_state();
        apb(1'b1, A_AR, 8'hFF);
        rd_chk("analog kept", A_AD, 8'hA5);
        apb(1'b1, A_SR, 8'h3F);
        rd_chk("six kept", A_SD, 8'h3F);
        apb(1'b1, A_TR, 8'hFF);
        rd_chk("timer kept", A_TD, 8'hC3);
        $display("test rerun_reset done");
    endtask : t_rerun_reset

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset for 12 cycles, wait past the reset synchroniser.
    initial begin
        {nrst, psel, penable, pwrite, sel_t1, sel_t2} = 6'b0;
        ce      = 1'b1;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        ext_b   = 8'h3C;
        ext_c   = 6'h15;
        ext_d   = 8'h5A;
        sel_b   = 8'h00;
        sel_d   = 7'h00;
        n_errors = 0;
        samples_checked = 0;
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
        t_reset_state();
        t_analog();
        t_six();
        t_timer();
        t_unmapped();
        t_rerun_reset();
        print_verdict();
    end
endmodule : gpio_ports_b_c_d_bench
